// *** hw/stcpw_pkg.sv ***
// Purpose: shared constants for the timer subsystem
// Assumes: 100 MHz interface clock
// Notes:   encodings of edge, action, restart and update selections
package stcpw_pkg;

  localparam int T24_W   = 24;
  localparam int PWM_W   = 16;
  localparam int PS_W    = 8;
  localparam int NUM_PWM = 4;
  localparam int NUM_CMP = 2;
  localparam int WD_W    = 16;
  localparam int T24_NINT = 5;
  localparam int PWM_NINT = 3;

  // capture edge selection
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // pin action on a compare event
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_SET    = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // pwm counter restart source
  localparam logic [1:0] RST_ROLL = 2'h0;
  localparam logic [1:0] RST_CMP0 = 2'h1;
  localparam logic [1:0] RST_CMP1 = 2'h2;
  localparam logic [1:0] RST_SW   = 2'h3;

  // shadow transfer: on own compare match or on either match
  localparam logic UPD_OWN = 1'b0;
  localparam logic UPD_ANY = 1'b1;

  // 24-bit timer interrupt flag positions
  localparam int T24_INT_ROLL = 0;
  localparam int T24_INT_CAP0 = 1;
  localparam int T24_INT_CAP1 = 2;
  localparam int T24_INT_CMP0 = 3;
  localparam int T24_INT_CMP1 = 4;

  // pwm interrupt flag positions
  localparam int PWM_INT_ROLL = 0;
  localparam int PWM_INT_CMP0 = 1;
  localparam int PWM_INT_CMP1 = 2;

  // watchdog timeout in slow oscillator ticks
  localparam logic [WD_W-1:0] WD_TIMEOUT_DEF = 16'h8000;

endpackage

// *** hw/stcpw_pwm_timer.sv ***
// Purpose: one 16-bit pwm timer with shadowed compares and pin actions
// Assumes: control inputs come from logic on the same clock
// Notes:   pinIn is a pin and is synchronised here
`timescale 1ns/1ps
`default_nettype none
module stcpw_pwm_timer
(
  input  wire logic                          clock,
  input  wire logic                          rstn,
  input  wire logic                          enable,
  input  wire logic [stcpw_pkg::PS_W-1:0]    prescale,
  input  wire logic                          updateMode,
  input  wire logic [1:0]                    cmpWrite,
  input  wire logic [stcpw_pkg::PWM_W-1:0]   cmpWrData,
  input  wire logic [1:0]                    resetSel,
  input  wire logic                          swReset,
  input  wire logic [1:0]                    action0,
  input  wire logic [1:0]                    action1,
  input  wire logic                          gpioMode,
  input  wire logic                          pinIn,
  input  wire logic [stcpw_pkg::PWM_NINT-1:0] intEnable,
  input  wire logic [stcpw_pkg::PWM_NINT-1:0] intClear,
  output logic                               pinOut,
  output logic                               pinOeN,
  output logic                               level,
  output logic [stcpw_pkg::PWM_NINT-1:0]     intFlags,
  output logic                               irq,
  output logic [stcpw_pkg::PWM_W-1:0]        count
);

  typedef struct packed {
    logic [stcpw_pkg::PS_W-1:0]                 ps;
    logic [stcpw_pkg::PWM_W-1:0]                cnt;
    logic [1:0][stcpw_pkg::PWM_W-1:0]           cmp;
    logic [1:0][stcpw_pkg::PWM_W-1:0]           shadow;
    logic [1:0]                                 pend;
    logic                                       lvl;
    logic [1:0]                                 pinSync;
    logic [stcpw_pkg::PWM_NINT-1:0]             flags;
  } stcpw_pwm_state_t;

  stcpw_pwm_state_t s_q;
  stcpw_pwm_state_t s_d;
  logic             tick;
  logic             roll;
  logic [1:0]       eq;
  logic             restart;

  function automatic logic applyAct(input logic lv, input logic [1:0] act);
    case (act)
      stcpw_pkg::ACT_SET:    applyAct = 1'b1;
      stcpw_pkg::ACT_CLEAR:  applyAct = 1'b0;
      stcpw_pkg::ACT_TOGGLE: applyAct = ~lv;
      default:               applyAct = lv;
    endcase
  endfunction

  always_comb
  begin
    s_d  = s_q;
    tick = enable && (s_q.ps == prescale); // R7 R20
    roll = tick && (s_q.cnt == '1);
    for (int i = 0; i < stcpw_pkg::NUM_CMP; i++)
    begin
      eq[i] = tick && (s_q.cnt == s_q.cmp[i]);
    end
    s_d.ps = (!enable || tick) ? '0 : s_q.ps + 1'b1; // R20
    // shadow moves to active only after a match
    for (int i = 0; i < stcpw_pkg::NUM_CMP; i++)
    begin
      if (s_q.pend[i] && (eq[i] || (updateMode == stcpw_pkg::UPD_ANY
          && (|eq))))
      begin
        s_d.cmp[i]  = s_q.shadow[i]; // R9
        s_d.pend[i] = 1'b0;
      end
      if (cmpWrite[i])
      begin
        s_d.shadow[i] = cmpWrData; // R9
        s_d.pend[i]   = 1'b1;
      end
    end
    restart = (resetSel == stcpw_pkg::RST_CMP0 && eq[0])
           || (resetSel == stcpw_pkg::RST_CMP1 && eq[1]); // R10
    if (tick)
    begin
      s_d.cnt = restart ? '0 : s_q.cnt + 1'b1; // R10
    end
    if (swReset)
    begin
      s_d.cnt = '0; // R10
      s_d.ps  = '0;
    end
    // compare 0 then compare 1 acts, so compare 1 wins a tie
    s_d.lvl = eq[0] ? applyAct(s_q.lvl, action0) : s_q.lvl; // R8 R12
    s_d.lvl = eq[1] ? applyAct(s_d.lvl, action1) : s_d.lvl; // R8 R12
    s_d.pinSync = {s_q.pinSync[0], pinIn};
    s_d.flags = (s_q.flags & ~intClear)
              | {eq[1], eq[0], roll}; // R11 R19
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pinOut   = s_q.lvl;
  assign pinOeN   = gpioMode;
  assign level    = gpioMode ? s_q.pinSync[1] : s_q.lvl; // R13
  assign intFlags = s_q.flags;
  assign irq      = |(s_q.flags & intEnable); // R11 R19
  assign count    = s_q.cnt;

endmodule
`default_nettype wire

// *** hw/stcpw_top.sv ***
// Purpose: 24-bit capture/compare timer, four pwm timers, watchdog
// Assumes: 100 MHz clock; capture pins and slow oscillator are async
// Notes:   slow oscillator is sampled and edge detected, no second domain
//
// How it works
// R1: 24-bit up counter behind 8-bit prescaler
// R2: two compare registers each raise interrupt
// R3: compare writes buffered, moved after a match
// R4: capture edge select rising, falling or both
// R5: capture copies counter into its data register
// R6: five enabled sources: rollover, captures, compares
// R7: four 16-bit pwm timers with prescalers
// R8: two compares set and reset pwm output
// R9: pwm compares shadowed, moved after a match
// R10: pwm restart on rollover, compare or software
// R11: pwm rollover and compare interrupts, enabled separately
// R12: compare event sets, clears, toggles or ignores
// R13: pwm level readable; pin usable as input
// R14: watchdog counts ticks of slow oscillator
// R15: watchdog expiry asserts processor reset
// R16: firmware restarts watchdog before it expires
// R17: watchdog off at reset, sticky once enabled
// R18: half timeout flag for firmware
// R19: flags sticky until cleared, gated by enables
// R20: prescale value N divides by N+1
`timescale 1ns/1ps
`default_nettype none
module stcpw_top
#(
  parameter logic [stcpw_pkg::WD_W-1:0] WD_TIMEOUT = stcpw_pkg::WD_TIMEOUT_DEF
)
(
  input  wire logic                                  clock,
  input  wire logic                                  rstn,
  input  wire logic                                  t24Enable,
  input  wire logic [stcpw_pkg::PS_W-1:0]            t24Prescale,
  input  wire logic                                  t24UpdateMode,
  input  wire logic [1:0]                            t24CmpWrite,
  input  wire logic [stcpw_pkg::T24_W-1:0]           t24CmpWrData,
  input  wire logic [1:0]                            t24CapEdgeFirst,
  input  wire logic [1:0]                            t24CapEdgeSecond,
  input  wire logic                                  captureInputFirst,
  input  wire logic                                  captureInputSecond,
  input  wire logic [stcpw_pkg::T24_NINT-1:0]        t24IntEnable,
  input  wire logic [stcpw_pkg::T24_NINT-1:0]        t24IntClear,
  output logic [stcpw_pkg::T24_W-1:0]                t24Count,
  output logic [stcpw_pkg::T24_W-1:0]                t24Compare0,
  output logic [stcpw_pkg::T24_W-1:0]                t24Compare1,
  output logic [stcpw_pkg::T24_W-1:0]                t24CapData0,
  output logic [stcpw_pkg::T24_W-1:0]                t24CapData1,
  output logic [stcpw_pkg::T24_NINT-1:0]             t24IntFlags,
  output logic                                       t24Irq,
  input  wire logic [stcpw_pkg::NUM_PWM-1:0]         pwmEnable,
  input  wire logic [stcpw_pkg::NUM_PWM-1:0][7:0]    pwmPrescale,
  input  wire logic [stcpw_pkg::NUM_PWM-1:0]         pwmUpdateMode,
  input  wire logic [stcpw_pkg::NUM_PWM-1:0][1:0]    pwmCmpWrite,
  input  wire logic [stcpw_pkg::NUM_PWM-1:0][15:0]   pwmCmpWrData,
  input  wire logic [stcpw_pkg::NUM_PWM-1:0][1:0]    pwmResetSel,
  input  wire logic [stcpw_pkg::NUM_PWM-1:0]         pwmSwReset,
  input  wire logic [stcpw_pkg::NUM_PWM-1:0][1:0]    pwmAction0,
  input  wire logic [stcpw_pkg::NUM_PWM-1:0][1:0]    pwmAction1,
  input  wire logic [stcpw_pkg::NUM_PWM-1:0]         pwmGpioMode,
  input  wire logic [stcpw_pkg::NUM_PWM-1:0]         pwmPinIn,
  input  wire logic [stcpw_pkg::NUM_PWM-1:0][2:0]    pwmIntEnable,
  input  wire logic [stcpw_pkg::NUM_PWM-1:0][2:0]    pwmIntClear,
  output logic [stcpw_pkg::NUM_PWM-1:0]              pwmPinOut,
  output logic [stcpw_pkg::NUM_PWM-1:0]              pwmPinOeN,
  output logic [stcpw_pkg::NUM_PWM-1:0]              pwmLevel,
  output logic [stcpw_pkg::NUM_PWM-1:0][2:0]         pwmIntFlags,
  output logic [stcpw_pkg::NUM_PWM-1:0]              pwmIrq,
  output logic [stcpw_pkg::NUM_PWM-1:0][15:0]        pwmCount,
  input  wire logic                                  slowOsc,
  input  wire logic                                  wdEnableSet,
  input  wire logic                                  wdRestart,
  input  wire logic                                  wdHalfClear,
  output logic                                       wdEnabled,
  output logic                                       wdHalfFlag,
  output logic [stcpw_pkg::WD_W-1:0]                 wdCount,
  output logic                                       cpuResetReq
);

  localparam logic [stcpw_pkg::WD_W-1:0] WD_HALF = WD_TIMEOUT >> 1;
  localparam logic [stcpw_pkg::WD_W-1:0] WD_LAST = WD_TIMEOUT - 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // state of the 24-bit timer and the watchdog

  typedef struct packed {
    logic [stcpw_pkg::PS_W-1:0]               ps;
    logic [stcpw_pkg::T24_W-1:0]              cnt;
    logic [1:0][stcpw_pkg::T24_W-1:0]         cmp;
    logic [1:0][stcpw_pkg::T24_W-1:0]         shadow;
    logic [1:0]                               pend;
    logic [1:0][stcpw_pkg::T24_W-1:0]         cap;
    logic [1:0][1:0]                          capSync;
    logic [1:0]                               capPrev;
    logic [stcpw_pkg::T24_NINT-1:0]           flags;
    logic [1:0]                               oscSync;
    logic                                     oscPrev;
    logic                                     wdEn;
    logic [stcpw_pkg::WD_W-1:0]               wdCnt;
    logic                                     wdHalf;
    logic                                     wdFired;
  } stcpw_state_t;

  stcpw_state_t                s_q;
  stcpw_state_t                s_d;
  logic                        tick;
  logic                        roll;
  logic [1:0]                  eq;
  logic [1:0]                  capEv;
  logic [1:0]                  capLvl;
  logic [1:0][1:0]             edgeSel;
  logic                        rise;
  logic                        fall;
  logic                        wdTick;
  logic [stcpw_pkg::WD_W-1:0]  wdNext;

  assign edgeSel = {t24CapEdgeSecond, t24CapEdgeFirst};
  assign capLvl  = {captureInputSecond, captureInputFirst};

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    s_d    = s_q;
    rise   = 1'b0;
    fall   = 1'b0;
    wdNext = '0;

    // prescaler: value N gives a tick every N+1 clocks
    tick   = t24Enable && (s_q.ps == t24Prescale); // R1 R20
    s_d.ps = (!t24Enable || tick) ? '0 : s_q.ps + 1'b1; // R20
    roll   = tick && (s_q.cnt == '1);
    if (tick)
    begin
      s_d.cnt = s_q.cnt + 1'b1; // R1
    end

    // compare match and shadow transfer
    for (int i = 0; i < stcpw_pkg::NUM_CMP; i++)
    begin
      eq[i] = tick && (s_q.cnt == s_q.cmp[i]); // R2
    end
    for (int i = 0; i < stcpw_pkg::NUM_CMP; i++)
    begin
      if (s_q.pend[i] && (eq[i] || (t24UpdateMode == stcpw_pkg::UPD_ANY
          && (|eq))))
      begin
        s_d.cmp[i]  = s_q.shadow[i]; // R3
        s_d.pend[i] = 1'b0;
      end
      if (t24CmpWrite[i])
      begin
        s_d.shadow[i] = t24CmpWrData; // R3
        s_d.pend[i]   = 1'b1;
      end
    end

    // capture pins: two flops, then edge detect on the second
    for (int i = 0; i < stcpw_pkg::NUM_CMP; i++)
    begin
      s_d.capSync[i] = {s_q.capSync[i][0], capLvl[i]};
      s_d.capPrev[i] = s_q.capSync[i][1];
      rise = s_q.capSync[i][1] && !s_q.capPrev[i];
      fall = !s_q.capSync[i][1] && s_q.capPrev[i];
      case (edgeSel[i])
        stcpw_pkg::EDGE_RISE: capEv[i] = rise; // R4
        stcpw_pkg::EDGE_FALL: capEv[i] = fall; // R4
        stcpw_pkg::EDGE_BOTH: capEv[i] = rise || fall; // R4
        default:              capEv[i] = 1'b0;
      endcase
      if (capEv[i])
      begin
        s_d.cap[i] = s_q.cnt; // R5
      end
    end

    // sticky flags, a new event beats a clear in the same cycle
    s_d.flags = s_q.flags & ~t24IntClear;
    s_d.flags[stcpw_pkg::T24_INT_ROLL] =
      s_d.flags[stcpw_pkg::T24_INT_ROLL] | roll; // R6 R19
    s_d.flags[stcpw_pkg::T24_INT_CAP0] =
      s_d.flags[stcpw_pkg::T24_INT_CAP0] | capEv[0]; // R6 R19
    s_d.flags[stcpw_pkg::T24_INT_CAP1] =
      s_d.flags[stcpw_pkg::T24_INT_CAP1] | capEv[1]; // R6 R19
    s_d.flags[stcpw_pkg::T24_INT_CMP0] =
      s_d.flags[stcpw_pkg::T24_INT_CMP0] | eq[0]; // R2 R6 R19
    s_d.flags[stcpw_pkg::T24_INT_CMP1] =
      s_d.flags[stcpw_pkg::T24_INT_CMP1] | eq[1]; // R2 R6 R19

    // watchdog: slow oscillator rising edges become single-clock ticks
    s_d.oscSync = {s_q.oscSync[0], slowOsc};
    s_d.oscPrev = s_q.oscSync[1];
    wdTick      = s_q.oscSync[1] && !s_q.oscPrev; // R14

    // enable only ever sets; rstn alone clears it
    if (wdEnableSet)
    begin
      s_d.wdEn = 1'b1; // R17
    end

    if (wdHalfClear)
    begin
      s_d.wdHalf = 1'b0;
    end

    if (!s_q.wdEn || wdRestart)
    begin
      s_d.wdCnt = '0; // R16
    end
    else if (wdTick && !s_q.wdFired)
    begin
      wdNext    = s_q.wdCnt + 1'b1;
      s_d.wdCnt = wdNext;
      if (wdNext == WD_HALF)
      begin
        s_d.wdHalf = 1'b1; // R18
      end
      if (s_q.wdCnt == WD_LAST)
      begin
        s_d.wdFired = 1'b1; // R15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs of the 24-bit timer and the watchdog

  assign t24Count    = s_q.cnt;
  assign t24Compare0 = s_q.cmp[0];
  assign t24Compare1 = s_q.cmp[1];
  assign t24CapData0 = s_q.cap[0];
  assign t24CapData1 = s_q.cap[1];
  assign t24IntFlags = s_q.flags;
  assign t24Irq      = |(s_q.flags & t24IntEnable); // R6 R19
  assign wdEnabled   = s_q.wdEn;
  assign wdHalfFlag  = s_q.wdHalf;
  assign wdCount     = s_q.wdCnt;
  assign cpuResetReq = s_q.wdFired; // R15

  ////////////////////////////////////////////////////////////////////////////
  // pwm timers

  for (genvar g = 0; g < stcpw_pkg::NUM_PWM; g++)
  begin : gPwm
    stcpw_pwm_timer uPwm
    (
      .clock      (clock),
      .rstn       (rstn),
      .enable     (pwmEnable[g]),
      .prescale   (pwmPrescale[g]),
      .updateMode (pwmUpdateMode[g]),
      .cmpWrite   (pwmCmpWrite[g]),
      .cmpWrData  (pwmCmpWrData[g]),
      .resetSel   (pwmResetSel[g]),
      .swReset    (pwmSwReset[g]),
      .action0    (pwmAction0[g]),
      .action1    (pwmAction1[g]),
      .gpioMode   (pwmGpioMode[g]),
      .pinIn      (pwmPinIn[g]),
      .intEnable  (pwmIntEnable[g]),
      .intClear   (pwmIntClear[g]),
      .pinOut     (pwmPinOut[g]),
      .pinOeN     (pwmPinOeN[g]),
      .level      (pwmLevel[g]),
      .intFlags   (pwmIntFlags[g]),
      .irq        (pwmIrq[g]),
      .count      (pwmCount[g])
    );
  end

endmodule
`default_nettype wire

// *** dv/stcpw_properties.sv ***
// Purpose: concurrent checks on the timer subsystem ports
// Assumes: one clock domain, async active-low reset
// Notes:   bound to stcpw_top at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module stcpw_properties
(
  input  wire logic                               clock,
  input  wire logic                               rstn,
  input  wire logic                               t24Enable,
  input  wire logic [stcpw_pkg::PS_W-1:0]         t24Prescale,
  input  wire logic [stcpw_pkg::T24_NINT-1:0]     t24IntClear,
  input  wire logic [stcpw_pkg::T24_NINT-1:0]     t24IntEnable,
  input  wire logic [stcpw_pkg::T24_W-1:0]        t24Count,
  input  wire logic [stcpw_pkg::T24_W-1:0]        t24Compare0,
  input  wire logic [stcpw_pkg::T24_NINT-1:0]     t24IntFlags,
  input  wire logic                               t24Irq,
  input  wire logic [stcpw_pkg::NUM_PWM-1:0]      pwmGpioMode,
  input  wire logic [stcpw_pkg::NUM_PWM-1:0]      pwmPinOut,
  input  wire logic [stcpw_pkg::NUM_PWM-1:0]      pwmLevel,
  input  wire logic                               wdRestart,
  input  wire logic                               wdEnabled,
  input  wire logic [stcpw_pkg::WD_W-1:0]         wdCount,
  input  wire logic                               cpuResetReq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_t24_count_step:
    assert property ((t24Enable && t24Prescale == 8'h00)
      |=> t24Count == $past(t24Count) + 24'h000001) else $error("count step");
  a_t24_cmp_flag:
    assert property ((t24Enable && t24Prescale == 8'h00 &&
      t24Count == t24Compare0) |=> t24IntFlags[stcpw_pkg::T24_INT_CMP0])
      else $error("compare flag missing");
  a_flags_stay_set:
    assert property (1'b1 |=> ($past(t24IntFlags) & ~$past(t24IntClear)
      & ~t24IntFlags) == 5'h00) else $error("flag dropped");
  a_t24_irq_mask:
    assert property (t24Irq == |(t24IntFlags & t24IntEnable))
      else $error("irq mask");
  a_pwm_level_out:
    assert property ((pwmLevel & ~pwmGpioMode) == (pwmPinOut & ~pwmGpioMode))
      else $error("pwm level");
  a_wd_enable_held:
    assert property (wdEnabled |=> wdEnabled) else $error("watchdog disabled");
  a_wd_off_idle:
    assert property (!wdEnabled |-> wdCount == 16'h0000)
      else $error("disabled watchdog counts");
  a_wd_restart_zero:
    assert property (wdRestart |=> wdCount == 16'h0000) else $error("restart");
  a_cpu_reset_held:
    assert property (cpuResetReq |=> cpuResetReq) else $error("reset dropped");
endmodule

bind stcpw_top stcpw_properties stcpw_properties_i
(
  .clock, .rstn, .t24Enable, .t24Prescale, .t24IntClear, .t24IntEnable,
  .t24Count, .t24Compare0, .t24IntFlags, .t24Irq, .pwmGpioMode, .pwmPinOut,
  .pwmLevel, .wdRestart, .wdEnabled, .wdCount, .cpuResetReq
);
`default_nettype wire

// *** dv/stcpw_pin_model.sv ***
// Purpose: capture sources, pwm pin loads and slow oscillator
// Assumes: bench calls the tasks just after a falling clock edge
// Notes:   pin level resolved from design enable and external driver
`timescale 1ns/1ps
`default_nettype none
module stcpw_pin_model
(
  input  wire logic [stcpw_pkg::NUM_PWM-1:0] pinOut,
  input  wire logic [stcpw_pkg::NUM_PWM-1:0] pinOeN,
  output logic      [stcpw_pkg::NUM_PWM-1:0] pinIn,
  output logic      [1:0]                    capPins,
  output logic                               slowOsc
);
  logic [stcpw_pkg::NUM_PWM-1:0] extLevel;

  initial
  begin
    capPins = 2'h0;
    slowOsc = 1'b0;
    extLevel = 4'h0;
  end

  // free-running, unrelated to the interface clock
  always #83 slowOsc = ~slowOsc;

  // design drives while its enable is low, else the external load
  always_comb
  begin
    for (int i = 0; i < stcpw_pkg::NUM_PWM; i++)
      pinIn[i] = pinOeN[i] ? extLevel[i] : pinOut[i];
  end

  task automatic setCap(input int idx, input logic val);
    capPins[idx] = val;
  endtask

  task automatic setExt(input int idx, input logic val);
    extLevel[idx] = val;
  endtask
endmodule
`default_nettype wire

// *** dv/stcpw_tb_top.sv ***
// Purpose: self-checking bench for the timer subsystem
// Assumes: inputs change at the falling edge, watchdog timeout set to 8
// Notes:   counter kept frozen during captures for exact values
`timescale 1ns/1ps
`default_nettype none
module stcpw_tb_top;
  logic                 clock = 1'b0, rstn = 1'b0;
  logic                 t24Enable = 1'b0, t24UpdateMode = 1'b0;
  logic [7:0]           t24Prescale = 8'h00;
  logic [1:0]           t24CmpWrite = 2'h0, t24CapEdgeFirst = 2'h0;
  logic [1:0]           t24CapEdgeSecond = 2'h0;
  logic [23:0]          t24CmpWrData = 24'h000000;
  logic [4:0]           t24IntEnable = 5'h00, t24IntClear = 5'h00;
  logic [3:0]           pwmEnable = 4'h0, pwmUpdateMode = 4'h0;
  logic [3:0]           pwmSwReset = 4'h0, pwmGpioMode = 4'h0;
  logic [3:0][7:0]      pwmPrescale = '0;
  logic [3:0][1:0]      pwmCmpWrite = '0, pwmResetSel = '0;
  logic [3:0][1:0]      pwmAction0 = '0, pwmAction1 = '0;
  logic [3:0][15:0]     pwmCmpWrData = '0;
  logic [3:0][2:0]      pwmIntEnable = '0, pwmIntClear = '0;
  logic                 wdEnableSet = 1'b0, wdRestart = 1'b0;
  logic                 wdHalfClear = 1'b0, slowOsc, t24Irq, wdEnabled;
  logic                 wdHalfFlag, cpuResetReq;
  logic [1:0]           capPins;
  logic [23:0]          t24Count, t24Compare0, t24Compare1;
  logic [23:0]          t24CapData0, t24CapData1;
  logic [4:0]           t24IntFlags;
  logic [3:0]           pwmPinIn, pwmPinOut, pwmPinOeN, pwmLevel, pwmIrq;
  logic [3:0][2:0]      pwmIntFlags;
  logic [3:0][15:0]     pwmCount;
  logic [15:0]          wdCount;
  int                   errorCnt = 0, nTests = 0;

  always #5 clock = ~clock;

  stcpw_top #(.WD_TIMEOUT(16'h0008)) stcpw_top_i
  (
    .clock, .rstn, .t24Enable, .t24Prescale, .t24UpdateMode, .t24CmpWrite,
    .t24CmpWrData, .t24CapEdgeFirst, .t24CapEdgeSecond,
    .captureInputFirst(capPins[0]), .captureInputSecond(capPins[1]),
    .t24IntEnable, .t24IntClear, .t24Count, .t24Compare0, .t24Compare1,
    .t24CapData0, .t24CapData1, .t24IntFlags, .t24Irq, .pwmEnable,
    .pwmPrescale, .pwmUpdateMode, .pwmCmpWrite, .pwmCmpWrData, .pwmResetSel,
    .pwmSwReset, .pwmAction0, .pwmAction1, .pwmGpioMode, .pwmPinIn,
    .pwmIntEnable, .pwmIntClear, .pwmPinOut, .pwmPinOeN, .pwmLevel,
    .pwmIntFlags, .pwmIrq, .pwmCount, .slowOsc, .wdEnableSet, .wdRestart,
    .wdHalfClear, .wdEnabled, .wdHalfFlag, .wdCount, .cpuResetReq
  );

  stcpw_pin_model stcpw_pin_model_i
  (
    .pinOut(pwmPinOut), .pinOeN(pwmPinOeN), .pinIn(pwmPinIn),
    .capPins(capPins), .slowOsc(slowOsc)
  );

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stopTest();
    $display("errors %0d checks %0d", errorCnt, nTests);
    if (errorCnt == 0 && nTests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic tCompare();
    t24CmpWrData = 24'h000010;
    t24CmpWrite = 2'b11;
    @(negedge clock);
    t24CmpWrite = 2'b00;
    chk(t24Compare0, 24'h000000);
    t24Enable = 1'b1;
    repeat (3) @(negedge clock);
    t24Enable = 1'b0;
    chk(t24IntFlags[stcpw_pkg::T24_INT_CMP0], 1'b1);
    chk(t24Compare0, 24'h000010);
    chk(t24Compare1, 24'h000010);
    chk(t24Irq, 1'b0);
    t24IntEnable = 5'h08;
    @(negedge clock);
    chk(t24Irq, 1'b1);
    t24IntClear = 5'h08;
    @(negedge clock);
    t24IntClear = 5'h00;
    t24IntEnable = 5'h00;
    chk(t24IntFlags, 5'h10);
  endtask

  task automatic tPrescale();
    t24Prescale = 8'h03;
    t24Enable = 1'b1;
    repeat (9) @(negedge clock);
    t24Enable = 1'b0;
    t24Prescale = 8'h00;
    chk(t24Count, 24'h000005);
  endtask

  task automatic tCapture();
    for (int i = 0; i < 2; i++)
      for (int j = 1; j < 4; j++)
      begin
        t24CapEdgeFirst = j[1:0];
        t24CapEdgeSecond = j[1:0];
        for (int e = 1; e >= 0; e--)
        begin
          t24IntClear = 5'h1F;
          @(negedge clock);
          t24IntClear = 5'h00;
          stcpw_pin_model_i.setCap(i, e[0]);
          repeat (4) @(negedge clock);
          chk(t24IntFlags[1+i], j != (e ? 2 : 1));
        end
      end
    chk(t24CapData0, 24'h000005);
    chk(t24CapData1, 24'h000005);
  endtask

  task automatic tPwm();
    int hi [4] = '{0, 0, 0, 0};
    logic [15:0] mx = 16'h0000;
    pwmResetSel = {stcpw_pkg::RST_ROLL, stcpw_pkg::RST_SW,
                   stcpw_pkg::RST_CMP0, stcpw_pkg::RST_CMP1};
    pwmUpdateMode = 4'h2;
    pwmAction0 = {stcpw_pkg::ACT_SET, stcpw_pkg::ACT_NONE,
                  stcpw_pkg::ACT_TOGGLE, stcpw_pkg::ACT_SET};
    pwmAction1 = {6'h00, stcpw_pkg::ACT_CLEAR};
    pwmCmpWrData = {4{16'h0002}};
    pwmCmpWrite = {4{2'b01}};
    @(negedge clock);
    pwmCmpWrData = {4{16'h0005}};
    pwmCmpWrite = {4{2'b10}};
    @(negedge clock);
    pwmCmpWrite = '0;
    pwmIntEnable = {4{3'b010}};
    pwmGpioMode = 4'h4;
    stcpw_pin_model_i.setExt(2, 1'b1);
    pwmEnable = 4'hF;
    repeat (20) @(negedge clock);
    // timer 1: shadow 1 moves on a compare 0 match in either-match mode
    pwmIntClear[1] = 3'b100;
    pwmCmpWrData[1] = 16'h0001;
    pwmCmpWrite[1] = 2'b10;
    @(negedge clock);
    pwmIntClear[1] = 3'b000;
    pwmCmpWrite[1] = 2'b00;
    for (int k = 0; k < 12; k++)
    begin
      @(negedge clock);
      for (int t = 0; t < 4; t++)
        hi[t] += (pwmPinOut[t] === 1'b1);
      if (pwmCount[0] > mx)
        mx = pwmCount[0];
    end
    chk(hi[0], 6);
    chk(hi[1], 6);
    chk(hi[2], 0);
    chk(hi[3], 12);
    chk(mx, 16'h0005);
    chk(pwmIntFlags[0], 3'b110);
    chk(pwmIrq[0], 1'b1);
    chk(pwmLevel[2], 1'b1);
    chk(pwmPinOeN[2], 1'b1);
    pwmSwReset = 4'h1;
    @(negedge clock);
    pwmSwReset = 4'h0;
    chk(pwmCount[0], 16'h0000);
    chk(pwmCount[1], 16'h0000);
    chk(pwmCount[2], 16'h0022);
    chk(pwmCount[3], 16'h0022);
    chk(pwmIntFlags[1][stcpw_pkg::PWM_INT_CMP1], 1'b1);
    pwmEnable = 4'h0;
  endtask

  task automatic tWatchdog();
    int k;
    repeat (60) @(negedge clock);
    chk(wdEnabled, 1'b0);
    chk(wdCount, 16'h0000);
    wdEnableSet = 1'b1;
    @(negedge clock);
    wdEnableSet = 1'b0;
    for (k = 0; k < 400 && wdHalfFlag !== 1'b1; k++)
      @(negedge clock);
    chk(wdHalfFlag, 1'b1);
    if (wdHalfFlag !== 1'b1)
      stopTest();
    chk(cpuResetReq, 1'b0);
    wdRestart = 1'b1;
    wdHalfClear = 1'b1;
    @(negedge clock);
    wdRestart = 1'b0;
    wdHalfClear = 1'b0;
    chk(wdCount, 16'h0000);
    chk(wdHalfFlag, 1'b0);
    for (k = 0; k < 400 && cpuResetReq !== 1'b1; k++)
      @(negedge clock);
    chk(cpuResetReq, 1'b1);
    chk(wdEnabled, 1'b1);
    rstn = 1'b0;
    @(negedge clock);
    rstn = 1'b1;
    chk(wdEnabled, 1'b0);
    chk(cpuResetReq, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(negedge clock);
    rstn = 1'b1;
    @(negedge clock);
    tCompare();
    tPrescale();
    tCapture();
    tPwm();
    tWatchdog();
    stopTest();
  end
endmodule
`default_nettype wire
